// [vsl_pkg.sv]
/*
  Shared constants for the serial load link of the two-grid display driver.
  Assumes both ends run from one 100 MHz clock.
*/
`default_nettype none
package vsl_pkg;
  // Word layout
  localparam int SEG_BITS   = 84;
  localparam int SEG_OUTS   = 42;
  localparam int DIM_BITS   = 10;
  localparam int MODE_BITS  = 2;
  localparam int FRAME_SEG  = SEG_BITS + MODE_BITS;
  localparam int FRAME_DIM  = DIM_BITS + MODE_BITS;
  localparam int DEST_POS   = 0;
  localparam int ROLE_POS   = 1;
  localparam int WORD_POS   = 2;
  localparam logic DEST_DIM = 1'b1;
  localparam logic DEST_SEG = 1'b0;
  localparam logic ROLE_MST = 1'b0;
  localparam logic ROLE_SLV = 1'b1;
  // Grid timing
  localparam int GRID_PERIOD = 2048;
  localparam int GRID_W      = 11;
  // Link timing
  localparam int CLK_MHZ    = 100;
  localparam int T_HALF_NS  = 500;
  localparam int T_LOAD_NS  = 1000;
  localparam int HALF_CYC   = (T_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int LOAD_CYC   = (T_LOAD_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W      = 8;
  // Host register map
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_SEG0 = 8'h08;
  localparam logic [7:0] A_SEGMENT_OUT_FIRST = 8'h0c;
  localparam logic [7:0] A_SEG2 = 8'h10;
  localparam logic [7:0] A_DIM  = 8'h14;
  localparam int C_START = 0;
  localparam int C_KIND  = 1;
  localparam int C_ROLE  = 2;
  localparam logic [1:0] RESP_OK  = 2'b00;
  localparam logic [1:0] RESP_DEC = 2'b11;
endpackage
`default_nettype wire

// [vsl_link_if.sv]
/*
  Three-wire serial link between host and display driver.
  Assumes the bench instantiates it and connects both ends.
*/
`default_nettype none
interface vsl_link_if;
  logic ser_data;
  logic shift_clk;
  logic load_strobe;
  modport host   (output ser_data, output shift_clk, output load_strobe);
  modport device (input ser_data, input shift_clk, input load_strobe);
endinterface
`default_nettype wire

// [vsl_device.sv]
/*
  Driver end: serial shift path, mode decode, latches, grid phase and
  segment output gating. Assumes link pins and straps are asynchronous.
*/
// Summary of operation
// - Dimming 10 bits or segment 84 bits
// - Host appends role then destination bits
// - Role 0 master, 1 slave
// - Destination 1 dimming, 0 segment
// - First dimming bit is LSB
// - Bits 1-42 phase a, 43-84 phase b
// - Overlong transfer keeps last 86 bits
// - Short transfer reuses older shifted contents
// - Shift one bit per shift clock rise
// - Latch captures on strobe falling edge
// - One strobe yields dimming or segment latch
// - Host strobes before next shift clock
// - Blank input low forces segments low
// - Blanking leaves grids running
// - Segments dark until first segment word
// - Display on at first segment latch
// - Role pins select master, slave, test
// - Master drives phase select to slave
// - Grid period 2048 oscillator cycles
`default_nettype none
module vsl_device
  import vsl_pkg::*;
#(
  parameter int OSC_DIV = 195
) (
  // Clock, reset, enable
  input  wire logic                mclk,
  input  wire logic                nrst,
  input  wire logic                ce,
  // Link
  vsl_link_if.device               link,
  // Straps and blanking
  input  wire logic                role_pin_a,
  input  wire logic                role_pin_b,
  input  wire logic                blank_n,
  // Display outputs
  output logic [SEG_OUTS-1:0]      seg_out,
  output logic                     grid_phase_a,
  output logic                     grid_phase_b,
  output logic                     phase_sel,
  output logic [DIM_BITS-1:0]      dim_level,
  output logic                     test_mode
);
  if (OSC_DIV < 1 || OSC_DIV > 65536) begin : g_bad_div
    $error("OSC_DIV out of range");
  end

  ////////////////////////////////////////////////////////////////////
  // Synchronisers: data, clock, strobe, blank, pin a, pin b
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] s1_reg;
  logic [NSYNC-1:0] s2_reg;
  assign raw_in = {role_pin_b, role_pin_a, blank_n,
                   link.load_strobe, link.shift_clk, link.ser_data};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          s1_reg[g] <= 1'b0;
          s2_reg[g] <= 1'b0;
        end else if (ce) begin
          s1_reg[g] <= raw_in[g];
          s2_reg[g] <= s1_reg[g];
        end
      end
    end
  endgenerate

  wire d_s     = s2_reg[0];
  wire sck_s   = s2_reg[1];
  wire ld_s    = s2_reg[2];
  wire blank_s = s2_reg[3];
  wire pa_s    = s2_reg[4];
  wire pb_s    = s2_reg[5];

  logic sck_d_reg;
  logic ld_d_reg;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sck_d_reg <= 1'b0;
      ld_d_reg  <= 1'b0;
    end else if (ce) begin
      sck_d_reg <= sck_s;
      ld_d_reg  <= ld_s;
    end
  end

  wire sck_rise = sck_s & ~sck_d_reg;
  wire ld_fall  = ~ld_s & ld_d_reg;

  ////////////////////////////////////////////////////////////////////
  // Role decode
  wire is_slave = pb_s;
  wire is_test  = pa_s & ~pb_s;
  wire own_role = is_slave ? ROLE_SLV : ROLE_MST;

  ////////////////////////////////////////////////////////////////////
  // Shift path: one register for both word lengths, newest bit at 0
  logic [FRAME_SEG-1:0] sr_reg;
  logic [FRAME_SEG-1:0] sr_next;
  // Old bits slide up and fall off the top, so the last 86 stay
  assign sr_next = {sr_reg[FRAME_SEG-2:0], d_s};

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sr_reg <= '0;
    end else if (ce && sck_rise) begin
      sr_reg <= sr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Latches
  // Reorder: first bit received sits at the top of its frame in the shift register (bit 85 segment, bit 11 dimming)
  function automatic logic [SEG_BITS-1:0] seg_word(input logic [FRAME_SEG-1:0] s);
    logic [SEG_BITS-1:0] w;
    w = '0;
    for (int k = 0; k < SEG_BITS; k++) begin
      w[k] = s[FRAME_SEG-1-k];
    end
    return w;
  endfunction

  function automatic logic [DIM_BITS-1:0] dim_word(input logic [FRAME_SEG-1:0] s);
    logic [DIM_BITS-1:0] w;
    w = '0;
    for (int k = 0; k < DIM_BITS; k++) begin
      w[k] = s[FRAME_DIM-1-k];
    end
    return w;
  endfunction

  wire role_ok  = ld_fall & (sr_reg[ROLE_POS] == own_role);
  wire take_dim = role_ok & (sr_reg[DEST_POS] == DEST_DIM);
  wire take_seg = role_ok & (sr_reg[DEST_POS] == DEST_SEG);

  logic [SEG_BITS-1:0] seg_reg;
  logic                shown_reg;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      seg_reg   <= '0;
      dim_level <= '0;
      shown_reg <= 1'b0;
    end else if (ce) begin
      if (take_seg) begin
        seg_reg   <= seg_word(sr_reg);
        shown_reg <= 1'b1;
      end
      if (take_dim) begin
        dim_level <= dim_word(sr_reg);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Oscillator stand-in and grid phase
  logic [15:0]       pre_reg;
  logic [GRID_W-1:0] grid_reg;
  wire osc_tick = (pre_reg == 16'(OSC_DIV - 1));
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pre_reg  <= '0;
      grid_reg <= '0;
    end else if (ce) begin
      pre_reg <= osc_tick ? '0 : pre_reg + 16'h0001;
      if (osc_tick) begin
        grid_reg <= grid_reg + 11'h001;
      end
    end
  end

  // Slave follows master phase on its pin a; grids ignore blanking
  wire half_b   = grid_reg[GRID_W-1];
  wire phase_b  = is_slave ? pa_s : half_b;
  wire seg_on   = blank_s & shown_reg;

  logic [SEG_OUTS-1:0] seg_pick;
  assign seg_pick = phase_b ? seg_reg[SEG_BITS-1:SEG_OUTS]
                            : seg_reg[SEG_OUTS-1:0];

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      seg_out      <= '0;
      grid_phase_a <= 1'b0;
      grid_phase_b <= 1'b0;
      phase_sel    <= 1'b0;
      test_mode    <= 1'b0;
    end else if (ce) begin
      seg_out      <= seg_on ? seg_pick : '0;
      grid_phase_a <= ~phase_b;
      grid_phase_b <= phase_b;
      phase_sel    <= half_b;
      test_mode    <= is_test;
    end
  end
endmodule
`default_nettype wire

// [vsl_host.sv]
/*
  Host end: AXI4-Lite register slave that shifts a segment or dimming
  frame out over the link, mode bits last, then pulses the strobe.
*/
// Decided for this implementation: the AXI4-Lite register port and the address map.
`default_nettype none
module vsl_host
  import vsl_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        ce,
  // AXI4-Lite
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // Link
  vsl_link_if.host         link
);
  typedef enum logic [4:0] {
    H_IDLE = 5'h01, H_LOW = 5'h02, H_HIGH = 5'h04, H_LOAD = 5'h08, H_GAP = 5'h10
  } vsl_hstate_t;

  vsl_hstate_t      st_reg;
  logic [95:0]      seg_reg;
  logic [31:0]      dim_reg;
  logic             kind_reg;
  logic             role_reg;
  logic [6:0]       idx_reg;
  logic [TMR_W-1:0] tmr_reg;
  logic             sd_reg;
  logic             sck_reg;
  logic             ld_reg;

  ////////////////////////////////////////////////////////////////////
  // Frame in send order: word first, then role, then destination
  logic [FRAME_SEG-1:0] stream;
  always_comb begin
    stream = '0;
    if (kind_reg == DEST_DIM) begin
      stream[DIM_BITS-1:0] = dim_reg[DIM_BITS-1:0];
      stream[DIM_BITS]     = role_reg;
      stream[DIM_BITS+1]   = DEST_DIM;
    end else begin
      stream[SEG_BITS-1:0] = seg_reg[SEG_BITS-1:0];
      stream[SEG_BITS]     = role_reg;
      stream[SEG_BITS+1]   = DEST_SEG;
    end
  end
  wire [6:0] last_idx = (kind_reg == DEST_DIM) ? 7'(FRAME_DIM - 1)
                                                : 7'(FRAME_SEG - 1);
  wire tmr_done = (tmr_reg == '0);
  wire busy     = (st_reg != H_IDLE);

  ////////////////////////////////////////////////////////////////////
  // Bus decode
  wire wr_go = s_awvalid & s_wvalid & ~s_awready & ~s_bvalid;
  wire rd_go = s_arvalid & ~s_arready & ~s_rvalid;
  wire start = wr_go & (s_awaddr == A_CTRL) & s_wdata[C_START] & ~busy;
  wire wr_ok = (s_awaddr == A_CTRL) | (s_awaddr == A_SEG0) | (s_awaddr == A_SEGMENT_OUT_FIRST)
             | (s_awaddr == A_SEG2) | (s_awaddr == A_DIM);

  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case (s_araddr)
      A_CTRL:  rd_mux = {29'h0, role_reg, kind_reg, 1'b0};
      A_STAT:  rd_mux = {31'h0, busy};
      A_SEG0:  rd_mux = seg_reg[31:0];
      A_SEGMENT_OUT_FIRST:  rd_mux = seg_reg[63:32];
      A_SEG2:  rd_mux = {12'h000, seg_reg[83:64]};
      A_DIM:   rd_mux = {22'h0, dim_reg[DIM_BITS-1:0]};
      default: begin
        rd_mux = '0;
        rd_ok  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= RESP_OK;
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= '0;
      s_rresp   <= RESP_OK;
      seg_reg   <= '0;
      dim_reg   <= '0;
      kind_reg  <= DEST_SEG;
      role_reg  <= ROLE_MST;
    end else if (ce) begin
      s_awready <= wr_go;
      s_wready  <= wr_go;
      s_arready <= rd_go;
      if (wr_go) begin
        s_bvalid <= 1'b1;
        s_bresp  <= wr_ok ? RESP_OK : RESP_DEC;
        if (!busy && s_awaddr == A_CTRL) begin
          kind_reg <= s_wdata[C_KIND];
          role_reg <= s_wdata[C_ROLE];
        end
        if (s_awaddr == A_SEG0) seg_reg[31:0]  <= s_wdata;
        if (s_awaddr == A_SEGMENT_OUT_FIRST) seg_reg[63:32] <= s_wdata;
        if (s_awaddr == A_SEG2) seg_reg[95:64] <= {12'h000, s_wdata[19:0]};
        if (s_awaddr == A_DIM)  dim_reg        <= {22'h0, s_wdata[9:0]};
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
      if (rd_go) begin
        s_rvalid <= 1'b1;
        s_rdata  <= rd_mux;
        s_rresp  <= rd_ok ? RESP_OK : RESP_DEC;
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Link sequencer: clock divided from mclk, 1 MHz at most
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_reg  <= H_IDLE;
      idx_reg <= '0;
      tmr_reg <= '0;
      sd_reg  <= 1'b0;
      sck_reg <= 1'b0;
      ld_reg  <= 1'b0;
    end else if (ce) begin
      if (!tmr_done) tmr_reg <= tmr_reg - 8'h01;
      case (st_reg)
        H_IDLE: if (start) begin
          st_reg  <= H_LOW;
          idx_reg <= '0;
          tmr_reg <= TMR_W'(HALF_CYC);
        end
        H_LOW: if (tmr_done) begin
          sck_reg <= 1'b1;
          st_reg  <= H_HIGH;
          tmr_reg <= TMR_W'(HALF_CYC);
        end else begin
          sd_reg <= stream[idx_reg];
        end
        H_HIGH: if (tmr_done) begin
          sck_reg <= 1'b0;
          tmr_reg <= TMR_W'(HALF_CYC);
          if (idx_reg == last_idx) begin
            st_reg <= H_LOAD;
          end else begin
            idx_reg <= idx_reg + 7'h01;
            st_reg  <= H_LOW;
          end
        end
        H_LOAD: if (tmr_done && !ld_reg) begin
          ld_reg  <= 1'b1;
          tmr_reg <= TMR_W'(LOAD_CYC);
        end else if (tmr_done) begin
          ld_reg  <= 1'b0;
          tmr_reg <= TMR_W'(HALF_CYC);
          st_reg  <= H_GAP;
        end
        H_GAP: if (tmr_done) st_reg <= H_IDLE;
        default: st_reg <= H_IDLE;
      endcase
    end
  end

  assign link.ser_data    = sd_reg;
  assign link.shift_clk   = sck_reg;
  assign link.load_strobe = ld_reg;
endmodule
`default_nettype wire

// [vsl_link_props.sv]
/*
  Checker for the host-driven link: clock widths, data setup and hold,
  strobe width, frame length and the destination bit.
  Assumes it sits beside the link that joins host and device.
*/
`default_nettype none
module vsl_link_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Link
  input wire logic ser_data,
  input wire logic shift_clk,
  input wire logic load_strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  //////////////////////////////////////////////////////////////////////////
  logic [7:0] hi_reg, lo_reg, ld_reg, st_reg;
  logic [6:0] bits_reg;
  logic       sd_reg, last_reg;
  // Low and stable counters saturate so long idle spans never wrap
  wire        sc_rise   = shift_clk & (hi_reg == 8'h00);
  wire        ld_fall   = ~load_strobe & (ld_reg != 8'h00);
  wire [7:0]  hi_next   = shift_clk ? hi_reg + 8'h01 : 8'h00;
  wire [7:0]  lo_next   = shift_clk ? 8'h00 : lo_reg + {7'h00, ~&lo_reg};
  wire [7:0]  ld_next   = load_strobe ? ld_reg + 8'h01 : 8'h00;
  wire [7:0]  st_next   = (ser_data != sd_reg) ? 8'h00 : st_reg + {7'h00, ~&st_reg};
  wire [6:0]  bits_next = ld_fall ? 7'h00 : bits_reg + {6'h00, sc_rise};
  wire        last_next = sc_rise ? ser_data : last_reg;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      {hi_reg, lo_reg, ld_reg, st_reg, bits_reg, sd_reg, last_reg} <= '0;
    end else begin
      {hi_reg, lo_reg, ld_reg, st_reg} <= {hi_next, lo_next, ld_next, st_next};
      {bits_reg, sd_reg, last_reg} <= {bits_next, ser_data, last_next};
    end
  end
  //////////////////////////////////////////////////////////////////////////
  property p_no_overlap; !(shift_clk && load_strobe); endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("strobe overlaps clock");
  // Sequencer holds each level for its half count plus the edge cycle
  property p_clk_high; $fell(shift_clk) |-> hi_reg == 8'd51; endproperty
  a_clk_high: assert property (p_clk_high) else $error("clock high width");
  property p_clk_low; $rose(shift_clk) |-> lo_reg >= 8'd50; endproperty
  a_clk_low: assert property (p_clk_low) else $error("clock low width");
  property p_setup; $rose(shift_clk) |-> st_reg >= 8'd20; endproperty
  a_setup: assert property (p_setup) else $error("data setup short");
  property p_hold; shift_clk && $past(shift_clk) |-> $stable(ser_data); endproperty
  a_hold: assert property (p_hold) else $error("data moved while clock high");
  property p_strobe_w; $fell(load_strobe) |-> ld_reg == 8'd101; endproperty
  a_strobe_w: assert property (p_strobe_w) else $error("strobe width");
  property p_gap; $fell(load_strobe) |-> ##1 !shift_clk [*8]; endproperty
  a_gap: assert property (p_gap) else $error("clock too soon after strobe");
  property p_len; $rose(load_strobe) |-> bits_reg == 7'd86 || bits_reg == 7'd12; endproperty
  a_len: assert property (p_len) else $error("frame length");
  property p_dest; $rose(load_strobe) |-> (bits_reg == 7'd86) == !last_reg; endproperty
  a_dest: assert property (p_dest) else $error("destination bit");
endmodule
`default_nettype wire

// [vfd_serial_load_latch_tb.sv]
/*
  Bench: host drives master and slave devices over one link; a bit-bang
  driver feeds a third device overlong, short and dimming frames. Assumes OSC_DIV of 1.
*/
`default_nettype none
module vfd_serial_load_latch_tb
  import vsl_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk, nrst, blank_n, ra_x, lo, hi, s_awvalid, s_awready, s_wvalid, s_wready;
  logic        s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready, psel, tmode;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, rng, d;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp, r;
  logic [41:0] so [3];
  logic [9:0]  dl [3];
  logic        ga [3];
  logic        mq [$];
  logic [95:0] t1, t2;
  logic        ce, gb0;
  logic [42:0] held;
  int          num_errors, comparisons, k;
  vsl_link_if lk ();
  vsl_link_if lk2 ();
  //////////////////////////////////////////////////////////////////////////
  vsl_host i_vsl_host (.mclk, .nrst, .ce, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
    .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
    .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .link(lk));
  vsl_device #(.OSC_DIV(1)) i_vsl_device (.mclk, .nrst, .ce, .link(lk), .role_pin_a(lo),
    .role_pin_b(lo), .blank_n, .seg_out(so[0]), .grid_phase_a(ga[0]), .grid_phase_b(gb0),
    .phase_sel(psel), .dim_level(dl[0]), .test_mode());
  vsl_device #(.OSC_DIV(1)) i_vsl_device_slv (.mclk, .nrst, .ce, .link(lk),
    .role_pin_a(psel), .role_pin_b(hi), .blank_n, .seg_out(so[1]), .grid_phase_a(ga[1]),
    .grid_phase_b(), .phase_sel(), .dim_level(dl[1]), .test_mode());
  vsl_device #(.OSC_DIV(1)) i_vsl_device_aux (.mclk, .nrst, .ce, .link(lk2),
    .role_pin_a(ra_x), .role_pin_b(lo), .blank_n, .seg_out(so[2]), .grid_phase_a(ga[2]),
    .grid_phase_b(), .phase_sel(), .dim_level(dl[2]), .test_mode(tmode));
  vsl_link_props i_vsl_link_props (.mclk, .nrst, .ser_data(lk.ser_data),
    .shift_clk(lk.shift_clk), .load_strobe(lk.load_strobe));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [83:0] seen, input logic [83:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    s_awaddr <= a;
    s_wdata <= v;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    // No cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge mclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    rs = s_bresp;
    s_bready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    v = s_rdata;
    rs = s_rresp;
    s_rready <= 1'b0;
    @(posedge mclk);
  endtask
  // Poll busy coarsely; a frame lasts thousands of cycles
  task automatic frame(input logic kind, input logic role, input logic [83:0] w);
    if (kind) axw(A_DIM, {22'h0, w[9:0]}, r);
    else begin
      axw(A_SEG0, w[31:0], r);
      axw(A_SEGMENT_OUT_FIRST, w[63:32], r);
      axw(A_SEG2, {12'h0, w[83:64]}, r);
    end
    axw(A_CTRL, {29'h0, role, kind, 1'b1}, r);
    chk("ctrl resp", r, RESP_OK);
    d = 32'h1;
    for (int i = 0; i < 300 && d[0] !== 1'b0; i++) begin
      tick(50);
      axr(A_STAT, d, r);
    end
    chk("busy", d[0], 1'b0);
    tick(10);
  endtask
  task automatic wait_ga(input int n, input logic v);
    for (int i = 0; i < 5000 && ga[n] !== v; i++) @(posedge mclk);
    chk("grid", ga[n], v);
  endtask
  task automatic seg_chk(input int n, input logic [83:0] w);
    wait_ga(n, 1'b0);
    wait_ga(n, 1'b1);
    tick(3);
    chk("seg a", so[n], w[41:0]);
    wait_ga(n, 1'b0);
    tick(3);
    chk("seg b", so[n], w[83:42]);
  endtask
  // Bit-bang at 160 ns; model keeps the last 86 bits
  task automatic bb(input logic b);
    lk2.ser_data <= b;
    tick(8);
    lk2.shift_clk <= 1'b1;
    tick(8);
    lk2.shift_clk <= 1'b0;
    mq.push_back(b);
    if (mq.size() > 86) void'(mq.pop_front());
  endtask
  task automatic aux(input int n, input logic dest);
    logic [83:0] e;
    for (int i = 0; i < n - 2; i++) begin
      void'(xs());
      bb(rng[0]);
    end
    bb(ROLE_MST);
    bb(dest);
    tick(8);
    lk2.load_strobe <= 1'b1;
    tick(100);
    lk2.load_strobe <= 1'b0;
    lk2.ser_data <= ~dest;
    tick(20);
    for (int i = 0; i < 84; i++) e[i] = mq[i];
    if (dest) chk("aux dim", dl[2], e[83:74]);
    else seg_chk(2, e);
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #900000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    {rng, num_errors, comparisons, nrst, ra_x, lo, hi, blank_n} = {32'he0092dad, 64'h0, 5'h03};
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, s_awaddr, s_araddr, s_wdata} = '0;
    s_wstrb = 4'hf;
    ce = 1'b1;
    {lk2.ser_data, lk2.shift_clk, lk2.load_strobe} = 3'h0;
    repeat (86) mq.push_back(1'b0);
    tick(3);
    nrst <= 1'b1;
    tick(3);
    for (k = 0; k < 3; k++) chk("seg idle", so[k], 84'h0);
    axw(8'h40, 32'h1, r);
    chk("bad wr", r, RESP_DEC);
    axr(8'h40, d, r);
    chk("bad rd", {r, d}, {RESP_DEC, 32'h0});
    t1 = {xs(), xs(), xs()};
    t2 = {xs(), xs(), xs()};
    frame(1'b1, ROLE_SLV, t1[83:0]);
    chk("slv dim", dl[1], t1[9:0]);
    chk("mst dim", dl[0], 10'h0);
    chk("dim no seg", so[0], 84'h0);
    frame(1'b0, ROLE_MST, t1[83:0]);
    seg_chk(0, t1[83:0]);
    chk("slv seg", so[1], 84'h0);
    frame(1'b0, ROLE_SLV, t2[83:0]);
    seg_chk(1, t2[83:0]);
    frame(1'b1, ROLE_MST, t2[83:0]);
    chk("mst dim", dl[0], t2[9:0]);
    blank_n <= 1'b0;
    tick(5);
    seg_chk(0, 84'h0);
    chk("grid b", gb0, !ga[0]);
    blank_n <= 1'b1;
    tick(5);
    seg_chk(0, t1[83:0]);
    ra_x <= 1'b1;
    tick(5);
    chk("test", tmode, 1'b1);
    ra_x <= 1'b0;
    tick(5);
    chk("test", tmode, 1'b0);
    // Enable low for over half a grid period: nothing may move
    ce <= 1'b0;
    tick(2);
    held = {ga[0], so[0]};
    chk("ce seg", so[0], ga[0] ? t1[41:0] : t1[83:42]);
    tick(1500);
    chk("ce hold", {ga[0], so[0]}, held);
    ce <= 1'b1;
    tick(5);
    aux(90, DEST_SEG);
    aux(12, DEST_DIM);
    aux(22, DEST_SEG);
    tally_and_finish();
  end
endmodule
`default_nettype wire
